// ---- bsfe_exec.sv ----
// Execution unit for bit, shift, flag, compare, skip and branch operations.
// Assumes io_rdata_i returns the I/O byte at io_addr_i in the same cycle.
`timescale 1ns/1ps
`default_nettype none

module bsfe_exec (
    input  wire logic                         core_clk_i,
    input  wire logic                         rstn_i,
    input  wire logic                         start_i,
    input  wire bsfe_pkg::bsfe_op_t           op_i,
    input  wire logic [bsfe_pkg::DATA_W-1:0]  reg_data_i,
    input  wire logic [bsfe_pkg::DATA_W-1:0]  imm_i,
    input  wire logic [2:0]                   bit_sel_i,
    input  wire logic [2:0]                   flag_sel_i,
    input  wire logic [bsfe_pkg::OFFS_W-1:0]  branch_offset_i,
    input  wire logic                         next_two_word_i,
    input  wire logic [bsfe_pkg::IO_W-1:0]    io_addr_i,
    input  wire logic [bsfe_pkg::DATA_W-1:0]  io_rdata_i,
    output logic                              ready_o,
    output logic                              done_o,
    output logic                              rd_we_o,
    output logic [bsfe_pkg::DATA_W-1:0]       rd_wdata_o,
    output logic                              io_we_o,
    output logic [bsfe_pkg::IO_W-1:0]         io_waddr_o,
    output logic [bsfe_pkg::DATA_W-1:0]       io_wdata_o,
    output logic [bsfe_pkg::DATA_W-1:0]       status_flags_o,
    output logic [bsfe_pkg::PC_W-1:0]         pc_o
);
    import bsfe_pkg::*;

    logic [DATA_W-1:0] status_flags_reg;
    logic [DATA_W-1:0] status_flags_next;
    logic [PC_W-1:0]   pc_reg;
    logic [PC_W-1:0]   pc_next;
    logic [CNT_W-1:0]  busy_cnt_reg;
    logic [CNT_W-1:0]  extra_next;
    logic [DATA_W-1:0] result_next;
    logic              rd_we_next;
    logic              io_we_next;
    logic              accept;
    logic              sel_bit;
    logic              io_bit;
    logic              skip_hit;
    logic              branch_hit;
    logic [DATA_W-1:0] diff;
    logic [PC_W-1:0]   offset_ext;

    assign ready_o = (busy_cnt_reg == EXTRA_NONE);
    assign accept  = start_i && ready_o;
    assign sel_bit = reg_data_i[bit_sel_i];
    assign io_bit  = io_rdata_i[bit_sel_i];
    assign diff    = reg_data_i - imm_i;
    assign offset_ext = {{(PC_W-OFFS_W){branch_offset_i[OFFS_W-1]}},
                         branch_offset_i};

    always_comb begin
        case (op_i)
            skip_reg_bit_clear_op: skip_hit = !sel_bit;
            skip_reg_bit_set_op:   skip_hit = sel_bit;
            skip_io_bit_clear_op:  skip_hit = !io_bit;
            skip_io_bit_set_op:    skip_hit = io_bit;
            default:               skip_hit = 1'b0;
        endcase
    end

    always_comb begin
        case (op_i)
            branch_flag_set_op:   branch_hit = status_flags_reg[flag_sel_i];
            branch_flag_clear_op: branch_hit = !status_flags_reg[flag_sel_i];
            branch_signed_ge_op:  branch_hit = !(status_flags_reg[FLAG_N] ^
                                               status_flags_reg[FLAG_V]);
            default:              branch_hit = 1'b0;
        endcase
    end

    // Result, flags, write strobes and cycle count of the accepted operation
    always_comb begin
        logic c_out;
        c_out             = 1'b0;
        result_next       = reg_data_i;
        status_flags_next = status_flags_reg;
        rd_we_next        = 1'b0;
        io_we_next        = 1'b0;
        extra_next        = EXTRA_NONE;
        case (op_i)
            set_io_bit_op: begin
                result_next            = io_rdata_i;
                result_next[bit_sel_i] = 1'b1;
                io_we_next             = 1'b1;
                extra_next             = EXTRA_ONE;
            end
            clear_io_bit_op: begin
                result_next            = io_rdata_i;
                result_next[bit_sel_i] = 1'b0;
                io_we_next             = 1'b1;
                extra_next             = EXTRA_ONE;
            end
            shift_left_logical_op: begin
                result_next = {reg_data_i[6:0], 1'b0};
                c_out       = reg_data_i[7];
                rd_we_next  = 1'b1;
            end
            shift_right_logical_op: begin
                result_next = {1'b0, reg_data_i[7:1]};
                c_out       = reg_data_i[0];
                rd_we_next  = 1'b1;
            end
            rotate_left_carry_op: begin
                result_next = {reg_data_i[6:0],
                               status_flags_reg[FLAG_C]};
                c_out       = reg_data_i[7];
                rd_we_next  = 1'b1;
            end
            rotate_right_carry_op: begin
                result_next = {status_flags_reg[FLAG_C],
                               reg_data_i[7:1]};
                c_out       = reg_data_i[0];
                rd_we_next  = 1'b1;
            end
            shift_right_arith_op: begin
                // Bit 7 kept so the sign survives
                result_next = {reg_data_i[7], reg_data_i[7:1]};
                c_out       = reg_data_i[0];
                rd_we_next  = 1'b1;
            end
            swap_nibbles_op: begin
                result_next = {reg_data_i[3:0], reg_data_i[7:4]};
                rd_we_next  = 1'b1;
            end
            bit_to_transfer_flag_op: begin
                status_flags_next[FLAG_T] = sel_bit;
            end
            transfer_flag_to_bit_op: begin
                result_next[bit_sel_i] = status_flags_reg[FLAG_T];
                rd_we_next             = 1'b1;
            end
            set_negative_op: status_flags_next[FLAG_N] = 1'b1;
            clear_negative_op: status_flags_next[FLAG_N] = 1'b0;
            flag_set_op: status_flags_next[flag_sel_i] = 1'b1;
            flag_clear_op: status_flags_next[flag_sel_i] = 1'b0;
            skip_reg_bit_clear_op, skip_reg_bit_set_op,
            skip_io_bit_clear_op, skip_io_bit_set_op: begin
                if (skip_hit) begin
                    extra_next = next_two_word_i ? EXTRA_TWO
                                                 : EXTRA_ONE;
                end
            end
            branch_flag_set_op, branch_flag_clear_op,
            branch_signed_ge_op: begin
                if (branch_hit) begin
                    extra_next = EXTRA_ONE;
                end
            end
            compare_imm_op: begin
                // Difference only feeds the flags; no write-back
                status_flags_next[FLAG_Z] = (diff == 8'h00);
                status_flags_next[FLAG_N] = diff[7];
                status_flags_next[FLAG_V] =
                    (reg_data_i[7] & ~imm_i[7] & ~diff[7]) |
                    (~reg_data_i[7] & imm_i[7] & diff[7]);
                status_flags_next[FLAG_C] =
                    (~reg_data_i[7] & imm_i[7]) | (imm_i[7] & diff[7]) |
                    (diff[7] & ~reg_data_i[7]);
                status_flags_next[FLAG_H] =
                    (~reg_data_i[3] & imm_i[3]) | (imm_i[3] & diff[3]) |
                    (diff[3] & ~reg_data_i[3]);
            end
            default: begin
            end
        endcase
        // Shift group flags
        if (op_i == shift_left_logical_op || op_i == shift_right_logical_op ||
            op_i == rotate_left_carry_op || op_i == rotate_right_carry_op ||
            op_i == shift_right_arith_op) begin
            status_flags_next[FLAG_C] = c_out;
            status_flags_next[FLAG_Z] = (result_next == 8'h00);
            status_flags_next[FLAG_N] = result_next[7];
            status_flags_next[FLAG_V] = result_next[7] ^ c_out;
        end
    end

    always_comb begin
        if (branch_hit) begin
            pc_next = pc_reg + offset_ext + PC_STEP_ONE;
        end else if (skip_hit) begin
            pc_next = next_two_word_i ? pc_reg + PC_STEP_THREE
                                      : pc_reg + PC_STEP_TWO;
        end else begin
            pc_next = pc_reg + PC_STEP_ONE;
        end
    end

    // Busy counter holds off new operations for the extra cycles
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            busy_cnt_reg <= EXTRA_NONE;
        end else if (accept) begin
            busy_cnt_reg <= extra_next;
        end else if (busy_cnt_reg != EXTRA_NONE) begin
            busy_cnt_reg <= busy_cnt_reg - EXTRA_ONE;
        end
    end

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            done_o <= 1'b0;
        end else begin
            done_o <= (accept && extra_next == EXTRA_NONE) ||
                      (busy_cnt_reg == EXTRA_ONE);
        end
    end

    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            status_flags_reg <= FLAGS_RESET;
            pc_reg           <= PC_RESET;
        end else if (accept) begin
            status_flags_reg <= status_flags_next;
            pc_reg           <= pc_next;
        end
    end

    // Write-back lands in the cycle after acceptance, the second I/O cycle
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rd_we_o    <= 1'b0;
            io_we_o    <= 1'b0;
            rd_wdata_o <= 8'h00;
            io_wdata_o <= 8'h00;
            io_waddr_o <= 5'h00;
        end else begin
            rd_we_o <= accept && rd_we_next;
            io_we_o <= accept && io_we_next;
            if (accept) begin
                rd_wdata_o <= result_next;
                io_wdata_o <= result_next;
                io_waddr_o <= io_addr_i;
            end
        end
    end

    assign status_flags_o = status_flags_reg;
    assign pc_o           = pc_reg;

endmodule

`default_nettype wire

// ---- bsfe_pkg.sv ----
// Constants and types for the bit, shift and flag execution unit.
// Assumes the decoder outside hands over one operation code per instruction.
`default_nettype none
package bsfe_pkg;

    localparam int unsigned DATA_W = 8;
    localparam int unsigned PC_W   = 16;
    localparam int unsigned IO_W   = 5;
    localparam int unsigned OFFS_W = 7;
    localparam int unsigned CNT_W  = 2;

    // Status register bit positions
    localparam int unsigned FLAG_C = 0;
    localparam int unsigned FLAG_Z = 1;
    localparam int unsigned FLAG_N = 2;
    localparam int unsigned FLAG_V = 3;
    localparam int unsigned FLAG_S = 4;
    localparam int unsigned FLAG_H = 5;
    localparam int unsigned FLAG_T = 6;
    localparam int unsigned FLAG_I = 7;

    localparam logic [DATA_W-1:0] FLAGS_RESET = 8'h00;
    localparam logic [PC_W-1:0]   PC_RESET    = 16'h0000;

    // Cycle counts, minus one, as loaded into the busy counter
    localparam logic [CNT_W-1:0] EXTRA_NONE = 2'h0;
    localparam logic [CNT_W-1:0] EXTRA_ONE  = 2'h1;
    localparam logic [CNT_W-1:0] EXTRA_TWO  = 2'h2;

    // Program counter steps
    localparam logic [PC_W-1:0] PC_STEP_ONE   = 16'h0001;
    localparam logic [PC_W-1:0] PC_STEP_TWO   = 16'h0002;
    localparam logic [PC_W-1:0] PC_STEP_THREE = 16'h0003;

    typedef enum logic [4:0] {
        nop_op,
        set_io_bit_op,
        clear_io_bit_op,
        shift_left_logical_op,
        shift_right_logical_op,
        rotate_left_carry_op,
        rotate_right_carry_op,
        shift_right_arith_op,
        swap_nibbles_op,
        bit_to_transfer_flag_op,
        transfer_flag_to_bit_op,
        set_negative_op,
        clear_negative_op,
        flag_set_op,
        flag_clear_op,
        skip_reg_bit_clear_op,
        skip_reg_bit_set_op,
        skip_io_bit_clear_op,
        skip_io_bit_set_op,
        branch_flag_set_op,
        branch_flag_clear_op,
        branch_signed_ge_op,
        compare_imm_op
    } bsfe_op_t;

endpackage

`default_nettype wire

// ---- bsfe_monitor.sv ----
// Assertions on the ports of the bit, shift and flag execution unit.
// Bound to bsfe_exec; one clock, asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module bsfe_monitor (
    input wire logic               core_clk_i,
    input wire logic               rstn_i,
    input wire logic               start_i,
    input wire bsfe_pkg::bsfe_op_t op_i,
    input wire logic [7:0]         reg_data_i,
    input wire logic [2:0]         bit_sel_i,
    input wire logic [6:0]         branch_offset_i,
    input wire logic               next_two_word_i,
    input wire logic               ready_o,
    input wire logic               done_o,
    input wire logic               rd_we_o,
    input wire logic [7:0]         rd_wdata_o,
    input wire logic               io_we_o,
    input wire logic [7:0]         io_wdata_o,
    input wire logic [7:0]         status_flags_o,
    input wire logic [15:0]        pc_o
);
    import bsfe_pkg::*;
    wire        acc   = start_i && ready_o;
    // Carry out on top, then the byte with its sign bit kept
    wire [8:0]  asr_v = {reg_data_i[0], reg_data_i[7], reg_data_i[7:1]};
    wire [15:0] br_v  = pc_o + {{9{branch_offset_i[6]}}, branch_offset_i}
                        + 16'h0001;
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rstn_i);
    property p_sio; acc && op_i == set_io_bit_op |=> io_we_o && !ready_o
        && io_wdata_o[$past(bit_sel_i)] ##1 done_o && ready_o; endproperty
    a_sio: assert property (p_sio)
        else $error("set io bit wrong");
    property p_cio; acc && op_i == clear_io_bit_op |=> io_we_o && !ready_o
        && !io_wdata_o[$past(bit_sel_i)] ##1 done_o; endproperty
    a_cio: assert property (p_cio)
        else $error("clear io bit wrong");
    property p_lsl; acc && op_i == shift_left_logical_op |=> rd_we_o
        && done_o && rd_wdata_o == ($past(reg_data_i) << 1); endproperty
    a_lsl: assert property (p_lsl)
        else $error("left shift wrong");
    property p_asr; acc && op_i == shift_right_arith_op |=> rd_we_o
        && {status_flags_o[FLAG_C], rd_wdata_o} == $past(asr_v); endproperty
    a_asr: assert property (p_asr)
        else $error("arith shift wrong");
    property p_setn; acc && op_i == set_negative_op |=> status_flags_o
        == ($past(status_flags_o) | (8'h01 << FLAG_N)); endproperty
    a_setn: assert property (p_setn)
        else $error("set neg wrong");
    property p_brt; acc && op_i == branch_signed_ge_op && status_flags_o[FLAG_N]
        == status_flags_o[FLAG_V] |=> pc_o == $past(br_v) && !ready_o
        ##1 done_o; endproperty
    a_brt: assert property (p_brt)
        else $error("taken branch wrong");
    property p_brn; acc && op_i == branch_signed_ge_op && status_flags_o[FLAG_N]
        != status_flags_o[FLAG_V] |=> done_o && pc_o == $past(pc_o) + 16'h0001
        && status_flags_o == $past(status_flags_o); endproperty
    a_brn: assert property (p_brn)
        else $error("branch skip wrong");
    property p_skp; acc && op_i == skip_reg_bit_clear_op && next_two_word_i
        && !reg_data_i[bit_sel_i] |=> pc_o == $past(pc_o) + 16'h0003
        && !ready_o ##1 !ready_o ##1 done_o; endproperty
    a_skp: assert property (p_skp)
        else $error("skip wrong");
endmodule
bind bsfe_exec bsfe_monitor u_bsfe_monitor (.core_clk_i, .rstn_i, .start_i,
    .op_i, .reg_data_i, .bit_sel_i, .branch_offset_i, .next_two_word_i,
    .ready_o, .done_o, .rd_we_o, .rd_wdata_o, .io_we_o, .io_wdata_o,
    .status_flags_o, .pc_o);
`default_nettype wire

// ---- bit_shift_flag_exec_test.sv ----
// Self-checking bench for the bit, shift and flag execution unit.
// Drives every operation except nop_op with random operands against a reference model.
`timescale 1ns/1ps
`default_nettype none
module bit_shift_flag_exec_test;
    import bsfe_pkg::*;
    logic        core_clk_i = 1'b0, rstn_i = 1'b0, start_i = 1'b0;
    logic        next_two_word_i = 1'b0;
    bsfe_op_t    op_i = nop_op;
    logic [7:0]  reg_data_i = 8'h00, imm_i = 8'h00, io_rdata_i = 8'h00;
    logic [2:0]  bit_sel_i = 3'h0, flag_sel_i = 3'h0;
    logic [6:0]  branch_offset_i = 7'h00;
    logic [4:0]  io_addr_i = 5'h00, io_waddr_o;
    logic        ready_o, done_o, rd_we_o, io_we_o;
    logic [7:0]  rd_wdata_o, io_wdata_o, status_flags_o, fl;
    logic [15:0] pc_o, pc;
    int          failures = 0, compares = 0, cycles = 0, seed = 79;
    bsfe_exec u_bsfe_exec (.core_clk_i, .rstn_i, .start_i, .op_i, .reg_data_i,
        .imm_i, .bit_sel_i, .flag_sel_i, .branch_offset_i, .next_two_word_i,
        .io_addr_i, .io_rdata_i, .ready_o, .done_o, .rd_we_o, .rd_wdata_o,
        .io_we_o, .io_waddr_o, .io_wdata_o, .status_flags_o, .pc_o);
    always #20 core_clk_i = ~core_clk_i;
    always @(posedge core_clk_i) begin
        cycles++;
        if (cycles > 8000) begin
            failures++;
            end_of_test();
        end
    end
    task automatic check(input logic [15:0] s, input logic [15:0] e);
        compares++;
        if (s !== e) begin
            failures++;
            $display("Error at %0t: saw %h expected %h", $time, s, e);
        end
    endtask
    task automatic end_of_test;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic release_reset;
        repeat (3) @(posedge core_clk_i);
        @(negedge core_clk_i);
        rstn_i = 1'b1;
        fl = FLAGS_RESET;
        pc = PC_RESET;
        check({7'h00, ready_o, status_flags_o}, {8'h01, fl});
        check(pc_o, pc);
        $display("reset test done");
    endtask
    task automatic do_op(input bsfe_op_t op);
        logic [7:0]  r, m, io, res, eio, ef;
        logic [15:0] ep;
        logic [2:0]  b, fs;
        logic [6:0]  k;
        logic [4:0]  a;
        logic        two, we, sk, bt, iw;
        int          cyc;
        {r, m, io} = 24'($random(seed));
        {b, fs, k, a, two} = 19'($random(seed));
        {reg_data_i, imm_i, io_rdata_i} = {r, m, io};
        {bit_sel_i, flag_sel_i, branch_offset_i} = {b, fs, k};
        {io_addr_i, next_two_word_i} = {a, two};
        op_i = op;
        start_i = 1'b1;
        {ef, res, eio, sk, bt} = {fl, r, io, 2'b00};
        {cyc, ep} = {32'd1, pc + 16'h1};
        iw = op inside {set_io_bit_op, clear_io_bit_op};
        case (op)
        set_io_bit_op, clear_io_bit_op: begin
            eio[b] = (op == set_io_bit_op);
            cyc = 2;
        end
        shift_left_logical_op: {ef[FLAG_C], res} = {r, 1'b0};
        shift_right_logical_op: {res, ef[FLAG_C]} = {1'b0, r};
        rotate_left_carry_op: {ef[FLAG_C], res} = {r, fl[FLAG_C]};
        rotate_right_carry_op: begin
            {res, ef[FLAG_C]} = {fl[FLAG_C], r};
        end
        shift_right_arith_op: {res, ef[FLAG_C]} = {r[7], r};
        swap_nibbles_op: res = {r[3:0], r[7:4]};
        bit_to_transfer_flag_op: ef[FLAG_T] = r[b];
        transfer_flag_to_bit_op: res[b] = fl[FLAG_T];
        set_negative_op, clear_negative_op: begin
            ef[FLAG_N] = (op == set_negative_op);
        end
        flag_set_op, flag_clear_op: ef[fs] = (op == flag_set_op);
        skip_reg_bit_clear_op, skip_reg_bit_set_op: begin
            sk = r[b] == (op == skip_reg_bit_set_op);
        end
        skip_io_bit_clear_op, skip_io_bit_set_op: begin
            sk = io[b] == (op == skip_io_bit_set_op);
        end
        branch_flag_set_op, branch_flag_clear_op: begin
            bt = fl[fs] == (op == branch_flag_set_op);
        end
        branch_signed_ge_op: bt = fl[FLAG_N] == fl[FLAG_V];
        compare_imm_op: begin
            res = r - m;
            // Borrows and signed overflow worked out from the operands
            ef[FLAG_H] = r[3:0] < m[3:0];
            ef[FLAG_V] = (r[7] != m[7]) && (res[7] != r[7]);
            {ef[FLAG_Z], ef[FLAG_N]} = {res == 8'h00, res[7]};
            ef[FLAG_C] = r < m;
        end
        default: ;
        endcase
        we = op inside {[shift_left_logical_op:swap_nibbles_op]}
            || op == transfer_flag_to_bit_op;
        if (op inside {[shift_left_logical_op:shift_right_arith_op]}) begin
            {ef[FLAG_Z], ef[FLAG_N]} = {res == 8'h00, res[7]};
            ef[FLAG_V] = res[7] ^ ef[FLAG_C];
        end
        if (sk) begin
            cyc = two ? 3 : 2;
            ep = pc + 16'(cyc);
        end
        if (bt) begin
            cyc = 2;
            ep = pc + {{9{k[6]}}, k} + 16'h0001;
        end
        @(posedge core_clk_i);
        for (int n = 1; n <= cyc; n++) begin
            @(negedge core_clk_i);
            check({ready_o, done_o}, {2{n == cyc}});
            check(status_flags_o, ef);
            check(pc_o, ep);
            if (n == 1) begin
                check({rd_we_o, io_we_o}, {we, iw});
                if (we) check(rd_wdata_o, res);
                if (iw) check({io_waddr_o, io_wdata_o}, {a, eio});
            end else begin
                check({rd_we_o, io_we_o}, 2'b00);
            end
            // Busy cycles carry junk requests that must be refused
            if (n < cyc) begin
                op_i = bsfe_op_t'($unsigned($random(seed)) % 23);
                reg_data_i = 8'($random(seed));
            end
        end
        fl = ef;
        pc = ep;
    endtask
    initial begin
        release_reset();
        repeat (40) for (int i = 1; i < 23; i++) do_op(bsfe_op_t'(i));
        start_i = 1'b0;
        $display("random operation test done");
        @(negedge core_clk_i);
        rstn_i = 1'b0;
        release_reset();
        repeat (10) for (int i = 1; i < 23; i++) do_op(bsfe_op_t'(i));
        $display("post reset operation test done");
        end_of_test();
    end
endmodule
`default_nettype wire
